// ### src/radio_cmd_pkg.sv
// Constants, types and helpers shared by the radio serial command port
`default_nettype none
package radio_cmd_pkg;

  // ==========================================================
  // Command word layout
  localparam int CMD_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam int TYPE_BIT = 15;
  localparam logic STATUS_READ_CODE = 1'b0;
  localparam int IDX_MSB = 14;
  localparam int IDX_LSB = 11;
  localparam int IDX_W = 4;
  localparam int DATA_W = 11;
  localparam int NUM_CFG = 16;

  // ==========================================================
  // Status word layout
  localparam int STICKY_W = 5;
  localparam int EVENT_W = 4;
  localparam int LIVE_W = 11;
  localparam int LOW_SUPPLY_BIT = 10;
  localparam logic [STICKY_W-1:0] STICKY_RESET = 5'h08;
  localparam logic [STICKY_W-1:0] STICKY_NONE = 5'h00;
  localparam logic [CMD_BITS-1:0] WORD_ZERO = 16'h0000;
  localparam logic [NUM_CFG-1:0][DATA_W-1:0] CFG_DEFAULTS = '0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_WAIT
  } link_state_type;

  function automatic logic [IDX_W-1:0] cmd_index(input logic [CMD_BITS-1:0] w);
    cmd_index = w[IDX_MSB:IDX_LSB];
  endfunction

  function automatic logic [DATA_W-1:0] cmd_data(input logic [CMD_BITS-1:0] w);
    cmd_data = w[DATA_W-1:0];
  endfunction

  // Sticky flags map to status bits 15..11, live levels to 10..0
  function automatic logic [CMD_BITS-1:0] status_word(input logic [STICKY_W-1:0] s,
                                                      input logic [LIVE_W-1:0] l);
    status_word = {s, l};
  endfunction

endpackage
`default_nettype wire

// ### src/cfg_store.sv
// Configuration word store with registered read port
`default_nettype none
module cfg_store
  import radio_cmd_pkg::*;
(
  input wire logic clk_in, // Core clock
  input wire logic rst_in, // Sync reset, active high
  input wire logic wr_en_in, // One-cycle write strobe
  input wire logic [IDX_W-1:0] wr_idx_in, // Word written
  input wire logic [DATA_W-1:0] wr_data_in, // Write data
  input wire logic [IDX_W-1:0] rd_idx_in, // Word read
  output logic [DATA_W-1:0] rd_data_out // Registered read data
);

  typedef struct packed {
    logic [NUM_CFG-1:0][DATA_W-1:0] words;
    logic [DATA_W-1:0] rdata;
  } store_type;

  store_type st_ff;
  store_type nxt_st;

  // ==========================================================
  // Only the addressed word changes; sleep never clears the store
  always_comb begin
    nxt_st = st_ff;
    if (wr_en_in) begin
      nxt_st.words[wr_idx_in] = wr_data_in;
    end
    nxt_st.rdata = st_ff.words[rd_idx_in];
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff.words <= CFG_DEFAULTS;
      st_ff.rdata <= CFG_DEFAULTS[0];
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data_out = st_ff.rdata;

endmodule
`default_nettype wire

// ### src/radio_serial_command_port.sv
// Serial command port: slave link, command decode, status word and interrupt
`default_nettype none
module radio_serial_command_port
  import radio_cmd_pkg::*;
(
  input wire logic CLK_IN, // Core clock, 100 MHz
  input wire logic RST_IN, // Sync reset, active high
  input wire logic SCK_IN, // Link clock from host
  input wire logic SEL_N_IN, // Chip select, active low
  input wire logic SDI_IN, // Serial data from host
  output logic SDO_OUT, // Serial data to host
  output logic SDO_OE_N_OUT, // Output enable, low = driving
  output logic IRQ_N_OUT, // Interrupt request, active low
  input wire logic SLEEP_IN, // Sleep mode level from core
  input wire logic [EVENT_W-1:0] EVENT_IN, // Event pulses: fifo, overflow, wake, ext
  input wire logic [LIVE_W-1:0] LIVE_STATUS_IN, // Live status levels
  input wire logic [radio_cmd_pkg::IDX_W-1:0] CFG_RD_IDX_IN, // Config word to view
  output logic [radio_cmd_pkg::DATA_W-1:0] CFG_RD_DATA_OUT, // Config word value
  output logic CFG_WR_OUT // Pulse after a config write
);
  import radio_cmd_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic sel_s1;
    logic sel_s2;
    logic sdi_s1;
    logic sdi_s2;
    link_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [CMD_BITS-1:0] shift_in;
    logic [CMD_BITS-1:0] shift_out;
    logic is_status;
    logic sdo;
    logic oe_n;
    logic [STICKY_W-1:0] sticky;
    logic irq_n;
    logic wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [DATA_W-1:0] wr_data;
  } port_type;

  port_type st_ff;
  port_type nxt_st;

  logic sck_rise;
  logic sck_fall;
  logic deselected;
  logic read_start;
  logic [STICKY_W-1:0] ev_bits;
  logic [CMD_BITS-1:0] word_now;

  // The host owns clock and select; both pass two flops first
  assign sck_rise = st_ff.sck_s2 & ~st_ff.sck_s3;
  assign sck_fall = ~st_ff.sck_s2 & st_ff.sck_s3;
  assign deselected = st_ff.sel_s2;
  assign read_start = sck_rise & ~deselected & (st_ff.state == ST_IDLE)
                      & (st_ff.sdi_s2 == STATUS_READ_CODE);
  assign ev_bits = {EVENT_IN[3], 1'b0, EVENT_IN[2:0]};
  assign word_now = {st_ff.shift_in[CMD_BITS-2:0], st_ff.sdi_s2};

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sck_s1 = SCK_IN;
    nxt_st.sck_s2 = st_ff.sck_s1;
    nxt_st.sck_s3 = st_ff.sck_s2;
    nxt_st.sel_s1 = SEL_N_IN;
    nxt_st.sel_s2 = st_ff.sel_s1;
    nxt_st.sdi_s1 = SDI_IN;
    nxt_st.sdi_s2 = st_ff.sdi_s1;
    nxt_st.wr_en = 1'b0;
    nxt_st.oe_n = 1'b0;

    if (deselected) begin
      // Any partial word is dropped here, never applied
      nxt_st.state = ST_IDLE;
      nxt_st.cnt = CNT_ZERO;
      nxt_st.is_status = 1'b0;
      nxt_st.shift_in = WORD_ZERO;
      nxt_st.shift_out = WORD_ZERO;
      nxt_st.sdo = 1'b0;
    end else begin
      if (sck_rise) begin
        unique case (st_ff.state)
          ST_IDLE: begin
            nxt_st.shift_in = word_now;
            nxt_st.cnt = CNT_ONE;
            nxt_st.state = ST_SHIFT;
            if (st_ff.sdi_s2 == STATUS_READ_CODE) begin
              // Snapshot before clearing so the host sees what fired
              nxt_st.is_status = 1'b1;
              nxt_st.shift_out = status_word(st_ff.sticky, LIVE_STATUS_IN);
            end
          end
          ST_SHIFT: begin
            nxt_st.shift_in = word_now;
            nxt_st.cnt = st_ff.cnt + CNT_ONE;
            if (st_ff.cnt == CNT_LAST) begin
              nxt_st.state = ST_WAIT;
              if (!st_ff.is_status) begin
                // Code selects one of the sixteen write words
                nxt_st.wr_en = 1'b1;
                nxt_st.wr_idx = cmd_index(word_now);
                nxt_st.wr_data = cmd_data(word_now);
              end
            end
          end
          ST_WAIT: begin
            // Clocks past the word are ignored until deselect
            nxt_st.state = ST_WAIT;
          end
        endcase
      end
      if (sck_fall && st_ff.is_status) begin
        nxt_st.sdo = st_ff.shift_out[CMD_BITS-1];
        nxt_st.shift_out = {st_ff.shift_out[CMD_BITS-2:0], 1'b0};
      end
    end

    // A flag set in the clearing cycle survives
    nxt_st.sticky = (read_start ? STICKY_NONE : st_ff.sticky) | ev_bits;
    nxt_st.irq_n = ~((|nxt_st.sticky) | LIVE_STATUS_IN[LOW_SUPPLY_BIT]);
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_ff <= '0;
      st_ff.state <= ST_IDLE;
      st_ff.sel_s1 <= 1'b1;
      st_ff.sel_s2 <= 1'b1;
      st_ff.oe_n <= 1'b1;
      st_ff.sticky <= STICKY_RESET;
      st_ff.irq_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Configuration store; sleep does not touch it
  cfg_store u_store (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .wr_en_in(st_ff.wr_en),
    .wr_idx_in(st_ff.wr_idx),
    .wr_data_in(st_ff.wr_data),
    .rd_idx_in(CFG_RD_IDX_IN),
    .rd_data_out(CFG_RD_DATA_OUT)
  );

  assign SDO_OUT = st_ff.sdo;
  assign SDO_OE_N_OUT = st_ff.oe_n;
  assign IRQ_N_OUT = st_ff.irq_n;
  assign CFG_WR_OUT = st_ff.wr_en;

  // ==========================================================
  // Checks
  sequence s_read_start;
    read_start && (EVENT_IN == '0) && !LIVE_STATUS_IN[LOW_SUPPLY_BIT];
  endsequence

  sequence s_flags_gone;
    (st_ff.sticky == STICKY_NONE) && IRQ_N_OUT;
  endsequence

  sequence s_status_fall;
    st_ff.is_status && sck_fall && !deselected;
  endsequence

  sdo_idle_low_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    deselected |=> !SDO_OUT && !SDO_OE_N_OUT)
    else $error("serial output not low while deselected");

  deselect_restart_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    deselected |=> (st_ff.cnt == CNT_ZERO) && (st_ff.state == ST_IDLE))
    else $error("receiver not reset on deselect");

  full_word_write_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    st_ff.wr_en |-> $past(sck_rise) && !$past(deselected) && ($past(st_ff.cnt) == CNT_LAST))
    else $error("write applied before sixteen bits");

  lead_bit_decode_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (sck_rise && !deselected && st_ff.state == ST_IDLE)
      |=> st_ff.is_status == ($past(st_ff.sdi_s2) == STATUS_READ_CODE))
    else $error("leading bit decoded wrongly");

  status_no_write_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    st_ff.wr_en |-> !$past(st_ff.is_status))
    else $error("status read caused a write");

  read_clears_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_read_start |=> s_flags_gone)
    else $error("status read did not clear flags");

  event_kept_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (EVENT_IN != '0) |=> (st_ff.sticky != STICKY_NONE) && !IRQ_N_OUT)
    else $error("event lost or interrupt not raised");

  sdo_on_fall_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ($changed(SDO_OUT) && !$past(deselected)) |-> $past(sck_fall))
    else $error("serial output moved off falling edge");

  msb_first_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_status_fall |=> SDO_OUT == $past(st_ff.shift_out[CMD_BITS-1]))
    else $error("status not sent msb first");

  sample_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (sck_rise && deselected) |=> (st_ff.cnt == CNT_ZERO))
    else $error("bit taken while deselected");

  one_write_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    st_ff.wr_en |=> !st_ff.wr_en)
    else $error("write strobe longer than one cycle");

  // ==========================================================
  // Reset, store and status checks
  // Store checks watch the read port, so they need the index held for a cycle
  sequence s_write_seen;
    CFG_WR_OUT && (CFG_RD_IDX_IN == st_ff.wr_idx) ##1 $stable(CFG_RD_IDX_IN);
  endsequence

  sequence s_other_seen;
    CFG_WR_OUT && (CFG_RD_IDX_IN != st_ff.wr_idx) ##1 $stable(CFG_RD_IDX_IN);
  endsequence

  por_flag_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $past(RST_IN) |-> (st_ff.sticky == STICKY_RESET) && IRQ_N_OUT && !SDO_OUT && !CFG_WR_OUT)
    else $error("state after reset is not the default");

  oe_driven_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !$past(RST_IN) |-> !SDO_OE_N_OUT)
    else $error("serial output not driven after reset");

  sleep_keeps_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (SLEEP_IN && $stable(CFG_RD_IDX_IN) && !$past(CFG_WR_OUT)) |=> $stable(CFG_RD_DATA_OUT))
    else $error("stored word changed during sleep");

  write_lands_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_write_seen |=> CFG_RD_DATA_OUT == $past(st_ff.wr_data, 2))
    else $error("written word not stored");

  write_others_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_other_seen |=> $stable(CFG_RD_DATA_OUT))
    else $error("write disturbed another word");

  write_type_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    st_ff.wr_en |-> ($past(word_now[TYPE_BIT]) != STATUS_READ_CODE))
    else $error("write taken from a status read code");

  cnt_bound_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (st_ff.cnt <= CNT_LAST) || (st_ff.state == ST_WAIT))
    else $error("bit count ran past the word");

  wait_holds_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (st_ff.state == ST_WAIT && !deselected) |=> (st_ff.state == ST_WAIT) && !st_ff.wr_en)
    else $error("extra clocks disturbed a finished word");

  status_snapshot_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    read_start |=> st_ff.is_status && (st_ff.shift_out[CMD_BITS-1:LIVE_W] == $past(st_ff.sticky)))
    else $error("status word does not carry the flags");

  write_quiet_sdo_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (!st_ff.is_status && !deselected) |=> !SDO_OUT)
    else $error("serial output moved outside a status read");

  sdo_stands_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (st_ff.is_status && !sck_fall && !deselected) |=> $stable(SDO_OUT))
    else $error("serial output moved between falling edges");

  deselect_clears_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    deselected |=> !st_ff.is_status)
    else $error("status mode kept after deselect");

  low_supply_irq_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    LIVE_STATUS_IN[LOW_SUPPLY_BIT] |=> !IRQ_N_OUT)
    else $error("low supply did not raise the interrupt");

  irq_cause_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !IRQ_N_OUT |-> (st_ff.sticky != STICKY_NONE) || $past(LIVE_STATUS_IN[LOW_SUPPLY_BIT]))
    else $error("interrupt raised with no cause");

endmodule
`default_nettype wire

// ### verification/host_model.sv
// Host-side serial master model that drives the command port link
`default_nettype none
module host_model (
  input wire logic clk_in, // Bench clock, used for pacing only
  input wire logic sdo_in, // Serial data from the device
  output logic sck_out, // Link clock, idles low
  output logic sel_n_out, // Chip select, active low
  output logic sdi_out // Serial data to the device
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sck_out = 1'b0;
    sel_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // ==========================================
  // One frame under a single select low
  // High 62 ns, low 63 ns: a 125 ns link period, well under 20 MHz
  // The 1 ns start offset keeps every link edge off the core clock's edges
  task automatic frame(input logic [15:0] word, input int nclk, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge clk_in);
    sel_n_out = 1'b0;
    sdi_out = word[15];
    repeat (5) @(negedge clk_in);
    #1;
    for (int i = 0; i < nclk; i++) begin
      sck_out = 1'b1;
      if (i > 0) rd = {rd[14:0], sdo_in};
      #62;
      sck_out = 1'b0;
      sdi_out = (i < 15) ? word[14 - i] : ~sdi_out;
      #63;
    end
    repeat (3) @(negedge clk_in);
    sel_n_out = 1'b1;
    // A released data line must not look like a held bit
    sdi_out = ~sdi_out;
    repeat (8) @(negedge clk_in);
  endtask

  // Clock pulses with select high, as when the host talks to another slave
  task automatic stray(input logic [15:0] word);
    @(negedge clk_in);
    #1;
    for (int i = 0; i < 16; i++) begin
      sdi_out = word[15 - i];
      #63;
      sck_out = 1'b1;
      #62;
      sck_out = 1'b0;
    end
    repeat (8) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the radio serial command port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import radio_cmd_pkg::*;

  logic clk, rst, sck, sel_n, sdi, sdo, sdo_oe_n, irq_n, sleep, cfg_wr;
  logic [EVENT_W-1:0] ev;
  logic [LIVE_W-1:0] live;
  logic [IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_data;
  logic [15:0] rd;
  int failures = 0;
  int tests_run = 0;
  int wr_cnt = 0;
  int cycles = 0;

  radio_serial_command_port dut_u (.CLK_IN(clk), .RST_IN(rst), .SCK_IN(sck), .SEL_N_IN(sel_n),
    .SDI_IN(sdi), .SDO_OUT(sdo), .SDO_OE_N_OUT(sdo_oe_n), .IRQ_N_OUT(irq_n), .SLEEP_IN(sleep),
    .EVENT_IN(ev), .LIVE_STATUS_IN(live), .CFG_RD_IDX_IN(rd_idx), .CFG_RD_DATA_OUT(rd_data),
    .CFG_WR_OUT(cfg_wr));
  host_model host_u (.clk_in(clk), .sdo_in(sdo), .sck_out(sck), .sel_n_out(sel_n), .sdi_out(sdi));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================
  // Write-pulse counting and hang guard
  // Counted on the falling edge, half a cycle after the rising edge that launches the strobe
  always @(negedge clk) begin
    cycles++;
    if (cfg_wr === 1'b1) wr_cnt++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // ==========================================
  // Compare and helper tasks
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic peek(input int idx, input logic [10:0] exp);
    @(negedge clk);
    rd_idx = idx[3:0];
    repeat (2) @(negedge clk);
    chk_word({5'h00, rd_data}, {5'h00, exp});
  endtask

  function automatic logic [10:0] cfg_val(input int i);
    return {i[3:0], 7'h2d};
  endfunction

  task automatic give_verdict();
    $display("checks=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic reset_state();
    chk_flag(sdo, 1'b0);
    chk_flag(sdo_oe_n, 1'b0);
    chk_flag(irq_n, 1'b0);
    for (int i = 0; i < 16; i++) peek(i, 11'h000);
  endtask

  task automatic write_all();
    for (int i = 0; i < 16; i++) host_u.frame({1'b1, i[3:0], cfg_val(i)}, 16, rd);
    chk_word(wr_cnt[15:0], 16'h0010);
    // Readback happens with sleep held to show values survive it
    sleep = 1'b1;
    for (int i = 0; i < 16; i++) peek(i, cfg_val(i));
    sleep = 1'b0;
  endtask

  task automatic partial_write();
    host_u.stray({1'b1, 4'h2, 11'h155});
    chk_word(wr_cnt[15:0], 16'h0010);
    peek(2, cfg_val(2));
    host_u.frame({1'b1, 4'h3, 11'h7ff}, 10, rd);
    chk_word(wr_cnt[15:0], 16'h0010);
    peek(3, cfg_val(3));
    host_u.frame({1'b1, 4'h3, 11'h7ff}, 16, rd);
    chk_word(wr_cnt[15:0], 16'h0011);
    peek(3, 11'h7ff);
    peek(2, cfg_val(2));
  endtask

  task automatic status_read();
    @(negedge clk);
    live = 11'h2a5;
    ev = 4'h9;
    @(negedge clk);
    ev = 4'h0;
    host_u.frame(16'h0000, 17, rd);
    chk_word(rd, {5'h19, 11'h2a5});
    chk_flag(irq_n, 1'b1);
    chk_flag(sdo, 1'b0);
    chk_word(wr_cnt[15:0], 16'h0011);
    host_u.frame(16'h0000, 17, rd);
    chk_word(rd, {5'h00, 11'h2a5});
  endtask

  task automatic low_supply();
    @(negedge clk);
    live = 11'h400;
    repeat (3) @(negedge clk);
    chk_flag(irq_n, 1'b0);
    host_u.frame(16'h0000, 17, rd);
    chk_word(rd, {5'h00, 11'h400});
    live = 11'h000;
    repeat (3) @(negedge clk);
    chk_flag(irq_n, 1'b1);
  endtask

  initial begin
    rst = 1'b1;
    sleep = 1'b0;
    ev = 4'h0;
    live = 11'h000;
    rd_idx = 4'h0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    reset_state();
    write_all();
    partial_write();
    status_read();
    low_supply();
    give_verdict();
  end
endmodule
`default_nettype wire
